// ==== hw/ebc_top.sv ====
// External bus control: mapping registers, address routing and port A pins.
// Assumes an APB master, a CPU request port on the same clock, mode pins static.
//
// What this block does
// - Follow space accesses stretched by its field
// - External accesses stretched zero to three bus clock periods
// - Follow stretch holds regardless of narrow bit
// - Single-chip and peripheral modes ignore stretch
// - Flash enable bits map arrays in or out
// - External bus runs eight or sixteen bits
// - Access size shown on low-byte strobe
// - Strobe, A0, read/write encode access type
// - Only RAM gives strobe and A0 high
// - Peripheral mode hides first sixteen registers
// - Expanded modes move port A/B registers out
// - Port E emulation moves port E out
// - Port A carries high address and data
// - Port A is GPIO in single-chip modes only
// - Direction bit: zero input, one output
// - Port A registers always accessible when mapped
// - Narrow follow bit makes follow space 8-bit
// - Map control writes once normal, always special
// - Reset: external stretch three, follow zero
`timescale 1ns/100ps
`default_nettype none
module ebc_top
  import ebc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Mode pins
  input wire logic [2:0] i_mode,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // CPU request port
  input wire logic i_cpu_req,
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_size16,
  input wire logic [15:0] i_cpu_wdata,
  input wire logic i_cpu_ram_hit,
  output logic o_cpu_ack,
  output logic [15:0] o_cpu_rdata,
  output logic o_small_flash_sel,
  output logic o_large_flash_sel,
  output logic o_reg_sel,
  output logic o_ram_misaligned,
  // External bus control pins
  output logic o_bus_phase_clock,
  output logic o_rw,
  output logic o_low_byte_strobe,
  // Port A pins
  input wire logic [7:0] i_pa,
  output logic [7:0] o_pa,
  output logic [7:0] o_pa_oe_n,
  // Port B pins
  input wire logic [7:0] i_pb,
  output logic [7:0] o_pb,
  output logic [7:0] o_pb_oe_n
);
  ebc_cyc_if cyc ();

  // Mode pins: two-flop synchroniser, then caught while reset is held
  logic [2:0] mode_s1_q, mode_s2_q;
  ebc_mode_t mode_q;
  logic expanded, special, narrow_mode, periph;

  always_ff @(posedge i_mclk)
  begin
    mode_s1_q <= i_mode;
    mode_s2_q <= mode_s1_q;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      mode_q <= ebc_mode_t'(mode_s2_q);
  end

  assign expanded = ebc_expanded(mode_q);
  assign special = ebc_special(mode_q);
  assign narrow_mode = ebc_narrow(mode_q);
  assign periph = (mode_q == EBC_PERIPHERAL);

  // Registers
  logic [7:0] pa_data_q, pa_data_d, pa_dir_q, pa_dir_d, misc_q, misc_d;
  logic misc_done_q, misc_done_d, emu_q, emu_d, emu_done_q, emu_done_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [4:0] idx;
  logic setup, wr_acc, aligned, pa_mapped, hit;
  logic [7:0] rd_val;

  assign idx = i_paddr[6:2];
  assign aligned = (i_paddr[1:0] == 2'b00) & (i_paddr[7] == 1'b0);
  assign setup = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite & ~pslverr_q;
  // Port A registers leave the map in expanded and peripheral modes
  assign pa_mapped = ~expanded & ~periph;

  always_comb
  begin
    hit = 1'b0;
    rd_val = 8'h00;
    unique case (idx)
      IDX_PORT_A_DATA:
      begin
        hit = pa_mapped;
        rd_val = pa_data_q;
      end
      IDX_PORT_A_DIR:
      begin
        hit = pa_mapped;
        rd_val = pa_dir_q;
      end
      IDX_MODE:
      begin
        hit = ~periph;
        rd_val = {1'b0, mode_q, 3'b000, emu_q};
      end
      IDX_MISC:
      begin
        hit = 1'b1;
        rd_val = misc_q;
      end
      default:
      begin
        hit = 1'b0;
        rd_val = 8'h00;
      end
    endcase
    if (~aligned)
      hit = 1'b0;
  end

  always_comb
  begin
    pa_data_d = pa_data_q;
    pa_dir_d = pa_dir_q;
    misc_d = misc_q;
    misc_done_d = misc_done_q;
    emu_d = emu_q;
    emu_done_d = emu_done_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup)
    begin
      prdata_d = (hit & ~i_pwrite) ? {24'h000000, rd_val} : 32'h00000000;
      pslverr_d = ~hit;
    end
    if (wr_acc)
    begin
      unique case (idx)
        IDX_PORT_A_DATA:
          pa_data_d = i_pwdata[7:0];
        IDX_PORT_A_DIR:
          pa_dir_d = i_pwdata[7:0];
        IDX_MODE:
          if (special | ~emu_done_q)
          begin
            emu_d = i_pwdata[MODE_EMULATE_E];
            emu_done_d = 1'b1;
          end
        IDX_MISC:
          // Normal modes lock after the first write so stray code cannot remap
          if (special | ~misc_done_q)
          begin
            misc_d = i_pwdata[7:0];
            misc_done_d = 1'b1;
          end
        default:
          misc_d = misc_q;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pa_data_q <= 8'h00;
      pa_dir_q <= 8'h00;
      misc_q <= expanded ? MISC_RST_EXP : MISC_RST_SC;
      misc_done_q <= 1'b0;
      emu_q <= 1'b0;
      emu_done_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pa_data_q <= pa_data_d;
      pa_dir_q <= pa_dir_d;
      misc_q <= misc_d;
      misc_done_q <= misc_done_d;
      emu_q <= emu_d;
      emu_done_q <= emu_done_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign o_pready = i_psel & i_penable;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q & i_psel & i_penable;

  // CPU address routing
  logic in_reg, in_follow, reg_gone, small_hit, large_hit, ext;
  logic [1:0] follow_str, ext_str;
  logic follow_narrow;

  assign follow_str = misc_q[MISC_FOLLOW_STR_LO +: 2];
  assign ext_str = misc_q[MISC_EXT_STR_LO +: 2];
  assign follow_narrow = misc_q[MISC_FOLLOW_NARROW];
  assign in_reg = (i_cpu_addr < REG_END);
  assign in_follow = ~in_reg & (i_cpu_addr < FOLLOW_END);
  // Port A and B data and direction sit in the first four register bytes
  assign reg_gone = (expanded & (i_cpu_addr[15:2] == 14'h0000))
    | (expanded & emu_q & ((i_cpu_addr == PORT_E_DATA_ADR)
    | (i_cpu_addr == PORT_E_DIR_ADR)))
    | (periph & (i_cpu_addr < 16'(IDX_EXPANSION_END)));

  always_comb
  begin
    if (misc_q[MISC_MAP_SWAP])
    begin
      small_hit = (i_cpu_addr >= SMALL_LO_SWAP);
      large_hit = (i_cpu_addr < LARGE_LO);
    end
    else
    begin
      small_hit = (i_cpu_addr >= SMALL_LO) & (i_cpu_addr < LARGE_LO);
      large_hit = (i_cpu_addr >= LARGE_LO);
    end
    small_hit = small_hit & misc_q[MISC_SMALL_FLASH] & ~in_reg;
    large_hit = large_hit & misc_q[MISC_LARGE_FLASH] & ~in_reg;
  end

  assign ext = expanded & ~i_cpu_ram_hit & ~small_hit & ~large_hit
    & (~in_reg | reg_gone);

  // Request sequencing
  typedef enum logic {CT_IDLE = 1'b0, CT_EXT = 1'b1} ebc_ct_t;
  ebc_ct_t ct_q, ct_d;
  logic [15:0] crd_q, crd_d;

  always_comb
  begin
    ct_d = ct_q;
    crd_d = crd_q;
    o_cpu_ack = 1'b0;
    cyc.start = 1'b0;
    unique case (ct_q)
      CT_IDLE:
        if (i_cpu_req & ext)
        begin
          cyc.start = 1'b1;
          ct_d = CT_EXT;
        end
        else if (i_cpu_req)
        begin
          o_cpu_ack = 1'b1;
          crd_d = 16'h0000;
        end
      CT_EXT:
        if (cyc.done)
        begin
          o_cpu_ack = 1'b1;
          crd_d = cyc.rdata;
          ct_d = CT_IDLE;
        end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      ct_q <= CT_IDLE;
      crd_q <= 16'h0000;
    end
    else
    begin
      ct_q <= ct_d;
      crd_q <= crd_d;
    end
  end

  assign o_cpu_rdata = crd_q;
  assign cyc.addr = i_cpu_addr;
  assign cyc.wr = i_cpu_wr;
  assign cyc.size16 = i_cpu_size16;
  assign cyc.wdata = i_cpu_wdata;
  // Stretch only matters when a cycle runs outside, which needs an expanded mode
  assign cyc.stretch = ~expanded ? 2'b00 : (in_follow ? follow_str : ext_str);
  assign cyc.narrow = narrow_mode | (in_follow & follow_narrow);
  assign o_small_flash_sel = i_cpu_req & (ct_q == CT_IDLE) & small_hit;
  assign o_large_flash_sel = i_cpu_req & (ct_q == CT_IDLE) & large_hit;
  assign o_reg_sel = i_cpu_req & (ct_q == CT_IDLE) & in_reg & ~reg_gone;
  assign o_ram_misaligned = i_cpu_req & i_cpu_ram_hit & i_cpu_size16 & i_cpu_addr[0];
  assign o_bus_phase_clock = cyc.e;
  assign o_rw = cyc.rw;
  assign o_low_byte_strobe = cyc.strobe;

  ebc_bus_seq u_seq (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .cyc(cyc.seq)
  );

  ebc_pin_mux #(.W(8)) u_port_a (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_bus_mode(expanded | periph),
    .i_bus_out(cyc.pa_out),
    .i_bus_drv(cyc.pa_drv),
    .i_gp_out(pa_data_q),
    .i_gp_dir(pa_dir_q),
    .i_pin(i_pa),
    .o_pin_out(o_pa),
    .o_pin_oe_n(o_pa_oe_n),
    .o_pin_sync(cyc.pa_in)
  );

  // Port B registers live elsewhere; here it only serves the bus
  ebc_pin_mux #(.W(8)) u_port_b (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_bus_mode(expanded | periph),
    .i_bus_out(cyc.pb_out),
    .i_bus_drv(cyc.pb_drv),
    .i_gp_out(8'h00),
    .i_gp_dir(8'h00),
    .i_pin(i_pb),
    .o_pin_out(o_pb),
    .o_pin_oe_n(o_pb_oe_n),
    .o_pin_sync(cyc.pb_in)
  );

  a_single_no_ext: assert property (@(posedge i_mclk) disable iff (i_srst)
    !expanded |-> !cyc.start)
    else $error("external cycle started outside expanded mode");
  a_flash_gate: assert property (@(posedge i_mclk) disable iff (i_srst)
    (o_small_flash_sel |-> misc_q[MISC_SMALL_FLASH])
    and (o_large_flash_sel |-> misc_q[MISC_LARGE_FLASH]))
    else $error("flash selected while disabled");
  a_periph_hidden: assert property (@(posedge i_mclk) disable iff (i_srst)
    setup && periph && aligned && idx < IDX_EXPANSION_END |=> o_pslverr)
    else $error("expansion register visible in peripheral mode");
  a_port_a_data_external: assert property (@(posedge i_mclk) disable iff (i_srst)
    ct_q == CT_IDLE && i_cpu_req && expanded && !i_cpu_ram_hit
    && i_cpu_addr < 16'h0004 |-> cyc.start ##1 ct_q == CT_EXT)
    else $error("port A address not sent outside");
  a_port_e_data_external: assert property (@(posedge i_mclk) disable iff (i_srst)
    ct_q == CT_IDLE && i_cpu_req && expanded && emu_q && !i_cpu_ram_hit
    && i_cpu_addr == PORT_E_DATA_ADR |-> cyc.start)
    else $error("port E address not sent outside");
  a_gpio_dir: assert property (@(posedge i_mclk) disable iff (i_srst)
    !expanded && !periph && $stable(pa_dir_q) |=> o_pa_oe_n == ~$past(pa_dir_q))
    else $error("port A direction not applied");
  a_misc_lock: assert property (@(posedge i_mclk) disable iff (i_srst)
    !special && misc_done_q && wr_acc && idx == IDX_MISC |=> $stable(misc_q))
    else $error("map control rewritten in normal mode");
  a_misc_reset: assert property (@(posedge i_mclk)
    $fell(i_srst) |-> misc_q[5:2] == 4'h3)
    else $error("stretch fields wrong after reset");
  a_stretch_pick: assert property (@(posedge i_mclk) disable iff (i_srst)
    cyc.start && in_follow |-> cyc.stretch == follow_str)
    else $error("follow space stretch not used");
  c_ext_read: cover property (@(posedge i_mclk) disable iff (i_srst)
    cyc.start && !i_cpu_wr ##[1:40] o_cpu_ack);
  c_split_word: cover property (@(posedge i_mclk) disable iff (i_srst)
    cyc.start && i_cpu_size16 && cyc.narrow);
  c_max_stretch: cover property (@(posedge i_mclk) disable iff (i_srst)
    cyc.start && cyc.stretch == 2'b11);
endmodule
`default_nettype wire

// ==== hw/ebc_pkg.sv ====
// Constants, types and helpers shared by the external bus control block.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
`default_nettype none
package ebc_pkg;
  // Clock and bus phase timing
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned E_LOW_NS = 40;
  localparam int unsigned E_HIGH_NS = 40;
  localparam int unsigned E_LOW_CYC = (E_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned E_HIGH_CYC = (E_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned E_PER_CYC = E_LOW_CYC + E_HIGH_CYC;
  localparam logic [3:0] E_LOW_CNT = 4'(E_LOW_CYC - 1);
  localparam logic [3:0] E_HIGH_CNT = 4'(E_HIGH_CYC - 1);
  localparam logic [3:0] E_PER_CNT = 4'(E_PER_CYC);

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_PORT_A_DATA = 5'h00;
  localparam logic [4:0] IDX_PORT_A_DIR = 5'h02;
  localparam logic [4:0] IDX_MODE = 5'h0b;
  localparam logic [4:0] IDX_MISC = 5'h13;
  localparam logic [4:0] IDX_EXPANSION_END = 5'h10;

  // Miscellaneous mapping control fields
  localparam int unsigned MISC_MAP_SWAP = 7;
  localparam int unsigned MISC_FOLLOW_NARROW = 6;
  localparam int unsigned MISC_FOLLOW_STR_LO = 4;
  localparam int unsigned MISC_EXT_STR_LO = 2;
  localparam int unsigned MISC_SMALL_FLASH = 1;
  localparam int unsigned MISC_LARGE_FLASH = 0;
  localparam logic [7:0] MISC_RST_EXP = 8'h0c;
  localparam logic [7:0] MISC_RST_SC = 8'h0f;
  localparam int unsigned MODE_EMULATE_E = 0;

  // CPU address map
  localparam logic [15:0] REG_END = 16'h0200;
  localparam logic [15:0] FOLLOW_END = 16'h0400;
  localparam logic [15:0] PORT_E_DATA_ADR = 16'h0008;
  localparam logic [15:0] PORT_E_DIR_ADR = 16'h0009;
  localparam logic [15:0] SMALL_LO = 16'h1000;
  localparam logic [15:0] SMALL_LO_SWAP = 16'h9000;
  localparam logic [15:0] LARGE_LO = 16'h8000;

  typedef enum logic [2:0] {
    EBC_SPC_SINGLE = 3'b000,
    EBC_SPC_NARROW = 3'b001,
    EBC_PERIPHERAL = 3'b010,
    EBC_SPC_WIDE = 3'b011,
    EBC_NRM_SINGLE = 3'b100,
    EBC_NRM_NARROW = 3'b101,
    EBC_NRM_RSVD = 3'b110,
    EBC_NRM_WIDE = 3'b111
  } ebc_mode_t;

  function automatic logic ebc_expanded(input ebc_mode_t m);
    return (m[0] == 1'b1);
  endfunction

  function automatic logic ebc_narrow(input ebc_mode_t m);
    return (m[1:0] == 2'b01);
  endfunction

  function automatic logic ebc_special(input ebc_mode_t m);
    return (m[2] == 1'b0);
  endfunction
endpackage
`default_nettype wire

// ==== hw/ebc_cyc_if.sv ====
// Carries one external bus cycle request and its pin-level drive.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ebc_cyc_if;
  logic start;
  logic [15:0] addr;
  logic wr;
  logic size16;
  logic [15:0] wdata;
  logic [1:0] stretch;
  logic narrow;
  logic done;
  logic [15:0] rdata;
  logic e;
  logic rw;
  logic strobe;
  logic [7:0] pa_out;
  logic pa_drv;
  logic [7:0] pb_out;
  logic pb_drv;
  logic [7:0] pa_in;
  logic [7:0] pb_in;
  modport ctl (output start, addr, wr, size16, wdata, stretch, narrow, pa_in, pb_in,
    input done, rdata, e, rw, strobe, pa_out, pa_drv, pb_out, pb_drv);
  modport seq (input start, addr, wr, size16, wdata, stretch, narrow, pa_in, pb_in,
    output done, rdata, e, rw, strobe, pa_out, pa_drv, pb_out, pb_drv);
endinterface
`default_nettype wire

// ==== hw/ebc_pin_mux.sv ====
// One port of pins: bus use or general-purpose use, with input synchroniser.
// Assumes pins are asynchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module ebc_pin_mux
  import ebc_pkg::*;
#(
  parameter int unsigned W = 8
)(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Selection and sources
  input wire logic i_bus_mode,
  input wire logic [W-1:0] i_bus_out,
  input wire logic i_bus_drv,
  input wire logic [W-1:0] i_gp_out,
  input wire logic [W-1:0] i_gp_dir,
  // Pins
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_pin_out,
  output logic [W-1:0] o_pin_oe_n,
  output logic [W-1:0] o_pin_sync
);
  logic [W-1:0] out_q, out_d, oe_n_q, oe_n_d, s1_q, s2_q;

  always_comb
  begin
    if (i_bus_mode)
    begin
      out_d = i_bus_out;
      oe_n_d = {W{~i_bus_drv}};
    end
    else
    begin
      out_d = i_gp_out;
      oe_n_d = ~i_gp_dir;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      out_q <= '0;
      oe_n_q <= '1;
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      s1_q <= i_pin;
      s2_q <= s1_q;
    end
  end

  assign o_pin_out = out_q;
  assign o_pin_oe_n = oe_n_q;
  assign o_pin_sync = s2_q;
endmodule
`default_nettype wire

// ==== hw/ebc_bus_seq.sv ====
// Sequencer for multiplexed external bus cycles with bus clock stretch.
// Assumes the controller holds the request fields only in the start cycle.
`timescale 1ns/100ps
`default_nettype none
module ebc_bus_seq
  import ebc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Cycle carrier
  ebc_cyc_if.seq cyc
);
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_LOW = 2'b01, SQ_HIGH = 2'b10} ebc_sq_t;
  ebc_sq_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] adr_q, adr_d, wd_q, wd_d, rd_q, rd_d;
  logic wr_q, wr_d, w16_q, w16_d, split_q, split_d, sec_q, sec_d, nar_q, nar_d;
  logic [1:0] str_q, str_d;
  logic done_q, done_d;
  logic [7:0] byte_w, byte_r;
  logic split_req;

  // Narrow or misaligned words go out as two byte cycles; RAM alone does one-cycle odd words
  assign split_req = cyc.size16 & (cyc.narrow | cyc.addr[0]);
  assign byte_w = sec_q ? wd_q[7:0] : (split_q ? wd_q[15:8] : wd_q[7:0]);
  assign byte_r = (nar_q | ~adr_q[0]) ? cyc.pa_in : cyc.pb_in;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    adr_d = adr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    wr_d = wr_q;
    w16_d = w16_q;
    split_d = split_q;
    sec_d = sec_q;
    nar_d = nar_q;
    str_d = str_q;
    done_d = 1'b0;
    unique case (st_q)
      SQ_IDLE:
        if (cyc.start)
        begin
          st_d = SQ_LOW;
          cnt_d = E_LOW_CNT;
          adr_d = cyc.addr;
          wd_d = cyc.wdata;
          rd_d = '0;
          wr_d = cyc.wr;
          split_d = split_req;
          w16_d = cyc.size16 & ~split_req;
          sec_d = 1'b0;
          nar_d = cyc.narrow;
          str_d = cyc.stretch;
        end
      SQ_LOW:
        if (cnt_q == 4'h0)
        begin
          st_d = SQ_HIGH;
          cnt_d = E_HIGH_CNT + 4'(str_q) * E_PER_CNT;
        end
        else
          cnt_d = cnt_q - 4'h1;
      SQ_HIGH:
        if (cnt_q == 4'h0)
        begin
          if (w16_q)
            rd_d = {cyc.pa_in, cyc.pb_in};
          else if (split_q & ~sec_q)
            rd_d[15:8] = byte_r;
          else
            rd_d[7:0] = byte_r;
          if (split_q & ~sec_q)
          begin
            st_d = SQ_LOW;
            cnt_d = E_LOW_CNT;
            adr_d = adr_q + 16'h0001;
            sec_d = 1'b1;
          end
          else
          begin
            st_d = SQ_IDLE;
            done_d = 1'b1;
          end
        end
        else
          cnt_d = cnt_q - 4'h1;
      default:
        st_d = SQ_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q <= SQ_IDLE;
      cnt_q <= 4'h0;
      adr_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      wr_q <= 1'b0;
      w16_q <= 1'b0;
      split_q <= 1'b0;
      sec_q <= 1'b0;
      nar_q <= 1'b0;
      str_q <= 2'b00;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      adr_q <= adr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      w16_q <= w16_d;
      split_q <= split_d;
      sec_q <= sec_d;
      nar_q <= nar_d;
      str_q <= str_d;
      done_q <= done_d;
    end
  end

  // Address in the low phase, data in the high phase
  always_comb
  begin
    cyc.e = (st_q == SQ_HIGH);
    cyc.rw = ~((st_q != SQ_IDLE) & wr_q);
    cyc.strobe = (st_q != SQ_IDLE) & ~w16_q & ~adr_q[0];
    cyc.pa_out = adr_q[15:8];
    cyc.pb_out = adr_q[7:0];
    cyc.pa_drv = (st_q == SQ_LOW);
    cyc.pb_drv = (st_q == SQ_LOW) | (nar_q & (st_q != SQ_IDLE));
    if (st_q == SQ_HIGH)
    begin
      cyc.pa_out = w16_q ? wd_q[15:8] : byte_w;
      cyc.pa_drv = wr_q;
      if (~nar_q)
      begin
        cyc.pb_out = w16_q ? wd_q[7:0] : byte_w;
        cyc.pb_drv = wr_q;
      end
    end
  end

  assign cyc.done = done_q;
  assign cyc.rdata = rd_q;

  // Helper: length of each high phase
  logic [3:0] hi_run_q;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      hi_run_q <= 4'h0;
    else
      hi_run_q <= (st_q == SQ_HIGH) ? hi_run_q + 4'h1 : 4'h0;
  end

  a_high_len: assert property (@(posedge i_mclk) disable iff (i_srst)
    $fell(cyc.e) |-> hi_run_q == E_HIGH_CNT + 4'h1 + 4'(str_q) * E_PER_CNT)
    else $error("bus clock high phase length wrong");
  a_no_odd_word: assert property (@(posedge i_mclk) disable iff (i_srst)
    cyc.e |-> !(cyc.strobe && adr_q[0]))
    else $error("external cycle shows odd word encoding");
endmodule
`default_nettype wire

// ==== bench/ebc_ext_mem.sv ====
// External memory model on the multiplexed bus.
// Assumes E high marks the data phase of a read.
`timescale 1ns/100ps
`default_nettype none
module ebc_ext_mem (
  // Bus pins
  input wire logic i_mclk,
  input wire logic i_e,
  input wire logic i_rw,
  output logic [7:0] o_pa,
  output logic [7:0] o_pb
);
  initial o_pa = 8'h00;
  initial o_pb = 8'h00;
  // Released lines toggle so stale data never passes for valid
  always @(posedge i_mclk)
  begin
    o_pa <= (i_e && i_rw) ? 8'h5a : ~o_pa;
    o_pb <= (i_e && i_rw) ? 8'hc3 : ~o_pb;
  end
endmodule
`default_nettype wire

// ==== bench/external_bus_control_test.sv ====
// Self-checking bench for the external bus control block.
// Assumes the memory model answers every external read.
`timescale 1ns/100ps
`default_nettype none
module external_bus_control_test;
  logic i_mclk = 0, i_srst = 1, psel = 0, pen = 0, pwr = 0, req = 0, pready, pslverr;
  logic ack, e, rw, errq, sz = 0, stb, sb;
  logic [15:0] rdat;
  logic [2:0] mode = 3'b011;
  logic [7:0] paddr = 8'h00, pa, pb, pa_o, pa_oe_n;
  logic [31:0] pwdata = 32'h0, prdata, rdq;
  logic [15:0] addr = 16'h0;
  int bad_count = 0, num_checks = 0, cyc = 0, n, h;
  initial forever #10 i_mclk = ~i_mclk;
  ebc_top ebc_top_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_mode(mode), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cpu_req(req), .i_cpu_addr(addr),
    .i_cpu_wr(1'b0), .i_cpu_size16(sz), .i_cpu_wdata(16'h0), .i_cpu_ram_hit(1'b0),
    .o_cpu_ack(ack), .o_cpu_rdata(rdat), .o_small_flash_sel(), .o_large_flash_sel(),
    .o_reg_sel(), .o_ram_misaligned(), .o_bus_phase_clock(e), .o_rw(rw),
    .o_low_byte_strobe(stb), .i_pa(pa), .o_pa(pa_o), .o_pa_oe_n(pa_oe_n), .i_pb(pb),
    .o_pb(), .o_pb_oe_n());
  ebc_ext_mem ebc_ext_mem_i (.i_mclk(i_mclk), .i_e(e), .i_rw(rw), .o_pa(pa), .o_pb(pb));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst(input logic [2:0] m);
    i_srst <= 1'b1;
    mode <= m;
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_mclk);
    pen <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Counts edges to the ack and edges with the bus clock high
  task automatic cpu(input logic [15:0] a, input logic s = 1'b0);
    @(posedge i_mclk);
    req <= 1'b1;
    addr <= a;
    sz <= s;
    n = 0;
    h = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
      h += int'(e === 1'b1);
      if (n == 2)
        sb = stb;
    end
    while (ack !== 1'b1);
    req <= 1'b0;
  endtask
  task automatic t_map;
    apb(1'b0, 8'h4c, 8'h00);
    cmp(rdq, 32'h0c);
    apb(1'b0, 8'h00, 8'h00);
    cmp(errq, 1);
  endtask
  task automatic t_stretch;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 8'h4c, 8'(s << 2));
      cpu(16'h4000);
      cmp(n, 6 + 4 * s);
      cmp(h, 2 + 4 * s);
      apb(1'b1, 8'h4c, 8'((s << 4) | ((s & 1) << 6) | 12));
      cpu(16'h0200);
      cmp(n, 6 + 4 * s);
    end
  endtask
  task automatic t_flash;
    apb(1'b1, 8'h4c, 8'h02);
    cpu(16'h4000);
    cmp(n, 1);
    apb(1'b1, 8'h4c, 8'h00);
    cpu(16'h4000);
    cmp(n, 6);
  endtask
  // Stretch one so the synchronised pins settle before capture
  task automatic t_size;
    apb(1'b1, 8'h4c, 8'h04);
    cpu(16'h4000, 1'b0);
    cmp(sb, 1);
    @(posedge i_mclk);
    cmp(rdat, 16'h005a);
    cpu(16'h4000, 1'b1);
    cmp(sb, 0);
    cmp(n, 10);
    @(posedge i_mclk);
    cmp(rdat, 16'h5ac3);
    cpu(16'h4001, 1'b1);
    cmp(n, 18);
    @(posedge i_mclk);
    cmp(rdat, 16'hc35a);
  endtask
  task automatic t_periph;
    apb(1'b0, 8'h00, 8'h00);
    cmp(errq, 1);
  endtask
  task automatic t_gpio;
    apb(1'b0, 8'h4c, 8'h00);
    cmp(rdq, 32'h0f);
    apb(1'b1, 8'h08, 8'hf0);
    apb(1'b1, 8'h00, 8'ha5);
    apb(1'b0, 8'h08, 8'h00);
    cmp(rdq, 32'hf0);
    repeat (3) @(posedge i_mclk);
    cmp(pa_oe_n, 8'h0f);
    cmp(pa_o & 8'hf0, 8'ha0);
  endtask
  task automatic t_once;
    apb(1'b1, 8'h4c, 8'h00);
    apb(1'b1, 8'h4c, 8'h0c);
    apb(1'b0, 8'h4c, 8'h00);
    cmp(rdq, 32'h00);
  endtask
  initial
  begin
    rst(3'b011);
    t_map();
    t_stretch();
    t_flash();
    t_size();
    rst(3'b000);
    t_gpio();
    rst(3'b111);
    t_once();
    rst(3'b010);
    t_periph();
    close_out();
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      close_out();
    end
  end
endmodule
`default_nettype wire
